// ===== design/watchdog_defs.vh
// Constants shared by the failsafe watchdog design files.
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH
// System clock period in ns (25 MHz).
`define CLK_PERIOD_NS 40
// Least width of a clear pulse, in ns.
`define CLEAR_MIN_NS 150
// Cycles a synchronised clear must stay low, rounded up, at least one.
`define CLEAR_MIN_CYC ((`CLEAR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Width of the clear-low counter.
`define CLEAR_CNT_W 3
// Default timeout period in oscillator ticks.
`define TIMEOUT_TICKS_DEF 24'h002710
// Default system clocks per oscillator tick (1 ms tick at 25 MHz).
`define TICK_DIV_DEF 16'h61a8
// Width of the timeout counter.
`define TIMEOUT_W 24
// Width of the tick divider.
`define TICK_W 16
`endif

// ===== design/sync2.v
// Two-flop synchroniser for single-bit asynchronous inputs.
`timescale 1ns/1ns
module sync2 #(
    parameter RESET_VAL = 1'b0
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_async,
    output wire o_sync
);
    // First stage, read only by the second stage.
    reg meta_q;
    // Second stage, safe for logic.
    reg sync_q;

    // Both stages reset to a constant so outputs are defined from reset.
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // sync2

// ===== design/failsafe_watchdog_timer.v
// Failsafe watchdog timer with power-up sequencing and supply supervision.
`timescale 1ns/1ns
`include "watchdog_defs.vh"
module failsafe_watchdog_timer #(
    parameter [`TIMEOUT_W-1:0] TIMEOUT_TICKS = `TIMEOUT_TICKS_DEF,
    parameter [`TICK_W-1:0] TICK_DIV = `TICK_DIV_DEF
) (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_timer_clear_n,
    input wire i_above_upper_threshold,
    input wire i_above_warning_threshold,
    input wire i_above_low_threshold,
    input wire i_above_supply_turn_on_level,
    input wire i_above_supply_turn_off_level,
    output wire o_timeout_warning_n,
    output wire o_system_hold_n,
    output wire o_power_fail_n
);
    // One-hot states of the supervisor.
    localparam [3:0] ST_OFF = 4'h1;
    localparam [3:0] ST_ARMED = 4'h2;
    localparam [3:0] ST_POWERUP = 4'h4;
    localparam [3:0] ST_WATCH = 4'h8;

    // Reset synchroniser: asynchronous assert, synchronous release.
    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Synchronised inputs; the clear idles high, comparators idle low (safe).
    wire clr_n_s;
    wire upper_s;
    wire warn_s;
    wire low_s;
    wire von_s;
    wire supply_turn_off_level_s;
    sync2 #(.RESET_VAL(1'b1)) u_sync_clr (.i_sys_clk(i_sys_clk), .i_rst_n(rst_n_q),
        .i_async(i_timer_clear_n), .o_sync(clr_n_s));
    sync2 #(.RESET_VAL(1'b0)) u_sync_up (.i_sys_clk(i_sys_clk), .i_rst_n(rst_n_q),
        .i_async(i_above_upper_threshold), .o_sync(upper_s));
    sync2 #(.RESET_VAL(1'b0)) u_sync_warn (.i_sys_clk(i_sys_clk), .i_rst_n(rst_n_q),
        .i_async(i_above_warning_threshold), .o_sync(warn_s));
    sync2 #(.RESET_VAL(1'b0)) u_sync_low (.i_sys_clk(i_sys_clk), .i_rst_n(rst_n_q),
        .i_async(i_above_low_threshold), .o_sync(low_s));
    sync2 #(.RESET_VAL(1'b0)) u_sync_von (.i_sys_clk(i_sys_clk), .i_rst_n(rst_n_q),
        .i_async(i_above_supply_turn_on_level), .o_sync(von_s));
    sync2 #(.RESET_VAL(1'b0)) u_sync_supply_turn_off_level (.i_sys_clk(i_sys_clk), .i_rst_n(rst_n_q),
        .i_async(i_above_supply_turn_off_level), .o_sync(supply_turn_off_level_s));

    // Clear qualification: count cycles the synchronised clear stays low.
    // A low lasting the minimum width fires exactly one pulse per low phase,
    // so a held-low clear acts once, as a falling edge should.
    // Last count before a clear qualifies, cut to the counter's width on purpose.
    localparam integer CLR_LAST_I = `CLEAR_MIN_CYC - 1;
    localparam [`CLEAR_CNT_W-1:0] CLR_LAST = CLR_LAST_I[`CLEAR_CNT_W-1:0];
    reg [`CLEAR_CNT_W-1:0] clr_cnt_q; // Cycles the synchronised clear has been low.
    reg clr_fired_q; // Set once this low phase has acted.
    wire clr_hit = !clr_n_s && !clr_fired_q && (clr_cnt_q == CLR_LAST);
    always @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            clr_cnt_q <= {`CLEAR_CNT_W{1'b0}};
            clr_fired_q <= 1'b0;
        end else if (clr_n_s) begin
            // Clear released: rearm the edge detector.
            clr_cnt_q <= {`CLEAR_CNT_W{1'b0}};
            clr_fired_q <= 1'b0;
        end else if (clr_hit) begin
            clr_fired_q <= 1'b1;
        end else if (!clr_fired_q) begin
            clr_cnt_q <= clr_cnt_q + 1'b1;
        end
    end

    // Supervisor state, timeout counter and output registers.
    reg [3:0] state_q; // One-hot supervisor state.
    reg [`TIMEOUT_W-1:0] cnt_q; // Ticks counted in the current period.
    reg to_n_q; // Timeout warning level.
    reg hold_n_q; // System hold level.
    reg pf_n_q; // Power-fail warning level.
    reg first_low_q; // Set through the first low phase of the warning.

    // Timer restart: entering the power-up delay or taking a clear also zeroes
    // the tick divider, so every period is a whole number of ticks and the hold
    // release lands exactly one period after the threshold is seen.
    // The trade-off is that the divider no longer runs as a free timebase.
    wire restart = ((state_q == ST_ARMED) && upper_s) || ((state_q == ST_WATCH) && clr_hit);

    // Oscillator timebase: one tick every TICK_DIV system clocks.
    reg [`TICK_W-1:0] div_q; // Clocks since the last tick.
    wire tick = (div_q == TICK_DIV - 1'b1);
    always @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q <= {`TICK_W{1'b0}};
        end else if (tick || restart) begin
            div_q <= {`TICK_W{1'b0}};
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // A period ends on the tick that completes the last count.
    wire period_end = tick && (cnt_q == TIMEOUT_TICKS - 1'b1);

    // Power-fail warning follows warning and upper thresholds with hysteresis.
    // The drops are tested first, so a sagging input can never let the
    // warning rise in the same cycle.
    always @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pf_n_q <= 1'b0;
        end else if (!supply_turn_off_level_s || !low_s || state_q == ST_OFF) begin
            pf_n_q <= 1'b0;
        end else if (!warn_s) begin
            pf_n_q <= 1'b0;
        end else if (upper_s && state_q != ST_ARMED) begin
            pf_n_q <= 1'b1;
        end
    end

    // Main sequence: off, armed, power-up delay, supervision.
    // Supply and low-threshold drops come first so they override the timer.
    always @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_OFF;
            cnt_q <= {`TIMEOUT_W{1'b0}};
            to_n_q <= 1'b1;
            hold_n_q <= 1'b0;
            first_low_q <= 1'b0;
        end else if (!supply_turn_off_level_s) begin
            // Supply collapsed: back to off with the count cleared, the hold low and the timeout warning high; the tick divider keeps running.
            state_q <= ST_OFF;
            cnt_q <= {`TIMEOUT_W{1'b0}};
            to_n_q <= 1'b1;
            hold_n_q <= 1'b0;
        end else if (!low_s && state_q != ST_OFF) begin
            // Low threshold overrides the timer; the only way out is a
            // fresh power-up, so clears are dead until then.
            state_q <= ST_ARMED;
            cnt_q <= {`TIMEOUT_W{1'b0}};
            to_n_q <= 1'b1;
            hold_n_q <= 1'b0;
        end else begin
            case (state_q)
                ST_OFF: begin
                    hold_n_q <= 1'b0;
                    to_n_q <= 1'b1;
                    cnt_q <= {`TIMEOUT_W{1'b0}};
                    if (von_s) begin
                        state_q <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    // Wait for the monitored voltage to reach the upper threshold.
                    cnt_q <= {`TIMEOUT_W{1'b0}};
                    if (upper_s) begin
                        state_q <= ST_POWERUP;
                    end
                end
                ST_POWERUP: begin
                    // Clears are not looked at during the power-on delay.
                    if (period_end) begin
                        state_q <= ST_WATCH;
                        hold_n_q <= 1'b1;
                        cnt_q <= {`TIMEOUT_W{1'b0}};
                        first_low_q <= 1'b0;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_WATCH: begin
                    if (clr_hit) begin
                        // A clear wins over a period end in the same cycle.
                        cnt_q <= {`TIMEOUT_W{1'b0}};
                        to_n_q <= 1'b1;
                        hold_n_q <= 1'b1;
                        first_low_q <= 1'b0;
                    end else if (period_end) begin
                        cnt_q <= {`TIMEOUT_W{1'b0}};
                        to_n_q <= !to_n_q;
                        if (to_n_q) begin
                            first_low_q <= 1'b1;
                        end else if (first_low_q) begin
                            // End of the first low phase: latch the hold.
                            hold_n_q <= 1'b0;
                            first_low_q <= 1'b0;
                        end
                    end else if (tick) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    assign o_timeout_warning_n = to_n_q;
    assign o_system_hold_n = hold_n_q;
    assign o_power_fail_n = pf_n_q;
endmodule // failsafe_watchdog_timer

// ===== dv/watchdog_checker.sv
// Port-level assertions for the failsafe watchdog.
`timescale 1ns/1ns
module watchdog_checker #(
    parameter int TIMEOUT_TICKS = 4,
    parameter int TICK_DIV = 3
) (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_timer_clear_n,
    input wire i_above_upper_threshold,
    input wire i_above_warning_threshold,
    input wire i_above_low_threshold,
    input wire i_above_supply_turn_on_level,
    input wire i_above_supply_turn_off_level,
    input wire o_timeout_warning_n,
    input wire o_system_hold_n,
    input wire o_power_fail_n
);
    localparam int TP = TIMEOUT_TICKS * TICK_DIV; // One timeout period in clocks.
    reg warn_q; // Last sampled warning level.
    reg [31:0] run_q; // Cycles the warning level has held.
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // Run length of the warning level; it saturates so that long idle spans stay legal.
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            warn_q <= 1'b1;
            run_q <= 32'h00000000;
        end else begin
            warn_q <= o_timeout_warning_n;
            run_q <= (o_timeout_warning_n != warn_q) ? 32'h00000001 :
                (run_q == 32'hffffffff) ? run_q : run_q + 32'h00000001;
        end
    end
    sequence supply_ok;
        (i_above_low_threshold && i_above_supply_turn_off_level) [*4];
    endsequence
    sequence hold_drop;
        $fell(o_system_hold_n);
    endsequence
    low_drop_a: assert property ((!i_above_low_threshold) [*4] |-> !o_system_hold_n && !o_power_fail_n)
        else $error("hold or power fail high below low threshold");
    warn_idle_a: assert property ((!i_above_low_threshold) [*4] |-> o_timeout_warning_n)
        else $error("warning active during low override");
    off_level_a: assert property ((!i_above_supply_turn_off_level) [*4] |-> !o_system_hold_n && !o_power_fail_n)
        else $error("outputs high with supply off");
    warn_drop_a: assert property ((!i_above_warning_threshold) [*4] |-> !o_power_fail_n)
        else $error("power fail high below warning threshold");
    hold_latch_a: assert property (supply_ok ##0 hold_drop |-> $rose(o_timeout_warning_n))
        else $error("hold fell outside end of first low phase");
    release_high_a: assert property ($rose(o_system_hold_n) |-> o_timeout_warning_n)
        else $error("hold released with warning low");
    power_rise_a: assert property ($rose(o_power_fail_n) |-> $past(i_above_upper_threshold, 2))
        else $error("power fail rose without upper threshold");
    warn_period_a: assert property (!o_timeout_warning_n && warn_q |-> run_q >= TP)
        else $error("warning fell before a full period");
endmodule // watchdog_checker

bind failsafe_watchdog_timer watchdog_checker #(.TIMEOUT_TICKS(TIMEOUT_TICKS), .TICK_DIV(TICK_DIV)) i_watchdog_checker (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_timer_clear_n(i_timer_clear_n),
    .i_above_upper_threshold(i_above_upper_threshold), .i_above_warning_threshold(i_above_warning_threshold),
    .i_above_low_threshold(i_above_low_threshold), .i_above_supply_turn_on_level(i_above_supply_turn_on_level),
    .i_above_supply_turn_off_level(i_above_supply_turn_off_level), .o_timeout_warning_n(o_timeout_warning_n),
    .o_system_hold_n(o_system_hold_n), .o_power_fail_n(o_power_fail_n));

// ===== dv/host_clear_model.sv
// Host processor model that issues timer clear pulses.
`timescale 1ns/1ns
module host_clear_model (
    input wire i_sys_clk,
    input wire i_kick,
    output reg o_timer_clear_n
);
    reg [2:0] cnt_q = 3'h0; // Cycles of low pulse left.
    initial o_timer_clear_n = 1'b1;
    // A kick starts a six-cycle low pulse, well over the least width; kicks while busy are dropped.
    always @(posedge i_sys_clk) begin
        if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
            o_timer_clear_n <= (cnt_q == 3'h1);
        end else if (i_kick) begin
            cnt_q <= 3'h6;
            o_timer_clear_n <= 1'b0;
        end
    end
endmodule // host_clear_model

// ===== dv/failsafe_watchdog_timer_tb.sv
// Self-checking testbench for the failsafe watchdog.
`timescale 1ns/1ns
module failsafe_watchdog_timer_tb;
    localparam int TP = 12; // Four ticks of three clocks.
    reg clk = 1'b0, rstn = 1'b0, kick = 1'b0, up = 1'b0, wth = 1'b0, low = 1'b0, on = 1'b0, off = 1'b0;
    wire clr_n, to_n, hold_n, pf_n;
    wire [2:0] outs = {pf_n, hold_n, to_n}; // Outputs by index for waits.
    int miscompares = 0, n_compared = 0, n;
    always #20 clk = ~clk;
    host_clear_model i_host_clear_model (.i_sys_clk(clk), .i_kick(kick), .o_timer_clear_n(clr_n));
    failsafe_watchdog_timer #(.TIMEOUT_TICKS(24'h000004), .TICK_DIV(16'h0003)) i_failsafe_watchdog_timer (
        .i_sys_clk(clk), .i_resetn(rstn), .i_timer_clear_n(clr_n), .i_above_upper_threshold(up),
        .i_above_warning_threshold(wth), .i_above_low_threshold(low), .i_above_supply_turn_on_level(on),
        .i_above_supply_turn_off_level(off), .o_timeout_warning_n(to_n), .o_system_hold_n(hold_n), .o_power_fail_n(pf_n));
    task final_report;
        if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits a bounded time for an output to reach a level; n holds the cycles spent.
    task wt(input int w, input logic v, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (outs[w] !== v && n < lim);
        if (outs[w] !== v) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, outs[w], v);
            final_report;
        end
    endtask
    // A clear during the power-on delay must not release the hold early.
    task power_up;
        {on, off, low, wth} <= 4'hf;
        cyc(4);
        up <= 1'b1;
        kick <= 1'b1;
        cyc(1);
        kick <= 1'b0;
        wt(1, 1'b1, TP + 40);
        chk(8'(n >= TP), 8'h01);
        // The second synchroniser flop and one state step sit inside the wait before the delay starts.
        chk(8'(n), 8'(TP + 2));
        chk(pf_n, 1'b1);
    endtask
    // Clears spaced under one period keep the warning high.
    task clears;
        repeat (5) begin
            cyc(1);
            kick <= 1'b1;
            cyc(1);
            kick <= 1'b0;
            cyc(8);
            #1 chk(to_n, 1'b1);
        end
    endtask
    // Missed deadlines: low phase, latched hold, toggling, then release by a clear.
    task timeout;
        wt(0, 1'b0, TP + 10);
        // The last clear was taken two edges before this wait began.
        chk(8'(n), 8'(TP - 2));
        chk(hold_n, 1'b1);
        wt(0, 1'b1, TP + 4);
        chk(8'(n), 8'(TP));
        chk(hold_n, 1'b0);
        wt(0, 1'b0, TP + 4);
        chk(8'(n), 8'(TP));
        chk(hold_n, 1'b0);
        cyc(1);
        kick <= 1'b1;
        cyc(1);
        kick <= 1'b0;
        wt(1, 1'b1, 12);
        chk(to_n, 1'b1);
    endtask
    // Power fail stays low after the warning threshold returns, until the upper one does.
    task warn_drop;
        cyc(1);
        {up, wth} <= 2'h0;
        cyc(5);
        #1 chk(pf_n, 1'b0);
        cyc(1);
        wth <= 1'b1;
        cyc(5);
        #1 chk(pf_n, 1'b0);
        cyc(1);
        up <= 1'b1;
        wt(2, 1'b1, 10);
    endtask
    // Low override ignores clears until a fresh power-up; a supply collapse then keeps hold and power fail low with the warning high.
    task low_drop;
        cyc(1);
        {up, low} <= 2'h0;
        cyc(4);
        #1 chk({hold_n, pf_n, to_n}, 3'h1);
        cyc(1);
        kick <= 1'b1;
        cyc(1);
        kick <= 1'b0;
        cyc(10);
        #1 chk({hold_n, pf_n}, 2'h0);
        cyc(1);
        off <= 1'b0;
        cyc(5);
        #1 chk({hold_n, pf_n, to_n}, 3'h1);
        cyc(1);
        {up, low, off} <= 3'h7;
        wt(1, 1'b1, TP + 40);
    endtask
    initial begin
        cyc(2);
        rstn <= 1'b1;
        cyc(3);
        power_up;
        clears;
        timeout;
        warn_drop;
        low_drop;
        final_report;
    end
endmodule // failsafe_watchdog_timer_tb
